// ### pkg/dram_seq_consts.vh
// constants for the dram access sequencer
`ifndef DRAM_SEQ_CONSTS_VH
`define DRAM_SEQ_CONSTS_VH
// column-width select codes
`define COLW_8          2'h0
`define COLW_9          2'h1
`define COLW_10         2'h2
`define COLW_BAD        2'h3
// row shift amounts per column width
`define SHIFT_8         4'h8
`define SHIFT_9         4'h9
`define SHIFT_10        4'hA
// position of the bit kept off the low pins in row phase in 1-megabyte mode
`define MB1_BIT         5'h14
// dram-area field codes
`define AREA_NONE       3'h0
// sequencer state codes
`define ST_IDLE         3'h0
`define ST_PRE          3'h1
`define ST_ROW          3'h2
`define ST_ROWW         3'h3
`define ST_COL1         3'h4
`define ST_COLW         3'h5
`define ST_COL2         3'h6
`define ST_GAP          3'h7
// wait counts
`define WAIT_MAX        2'h3
`endif

// ### verilog/addr_mux.v
// row/column address multiplexer
`timescale 1ns/1ns
`include "dram_seq_consts.vh"
module addr_mux #(
  parameter AW = 24
) (
  input  wire [AW-1:0] addr,
  input  wire [1:0]    colwidth_sel,
  input  wire          mode_1mb,
  input  wire          row_phase,
  output reg  [AW-1:0] pins
);
  reg [AW-1:0] shifted;
  reg [3:0]    sh;
  integer      i;
  always @* begin
    shifted = {AW{1'b0}};
    pins    = addr; // (R4)
    case (colwidth_sel) // (R1)
      `COLW_8:  sh = `SHIFT_8;
      `COLW_9:  sh = `SHIFT_9;
      `COLW_10: sh = `SHIFT_10;
      default:  sh = 4'h0;
    endcase
    if (row_phase && sh != 4'h0) begin
      shifted = addr >> sh; // (R2)
      for (i = 0; i < 13; i = i + 1) begin
        // only pins below the top of the shifted range carry row bits
        if (i + sh < 21)
          pins[i] = shifted[i];
      end
      for (i = 0; i < 13; i = i + 1) begin
        if ((i + sh == `MB1_BIT) && mode_1mb)
          pins[i] = addr[i]; // (R3)
      end
    end
  end
endmodule

// ### verilog/dram_access_sequencer.v
// dram access sequencer: strobes, address mux and state sequence
// Function
// (R1) column-width field selects 8, 9 or 10 column bits; 11 illegal
// (R2) row phase shifts address down by column width onto low pins
// (R3) in 1-megabyte mode bit 20 never reaches a low pin in row phase
// (R4) column phase presents unshifted address on every pin
// (R5) area bus-width bit 1 means 8-bit space, 0 means 16-bit
// (R6) 8-bit space enables upper byte lane only; 16-bit enables both
// (R7) strobe-pin select 0 uses port B pins, 1 uses write strobe pins
// (R8) row strobe of areas 2 to 5 drives area chip-select pin
// (R9) write enable on read strobe pin, high throughout reads
// (R10) refresh indicator low during refresh cycles, high otherwise; first precharge state uses the previous access's flag
// (R11) basic access: precharge, row, then two column states
// (R12) three-state bit only enables column waits; 0 inserts none
// (R13) write-strobe column strobes: idle state before non-dram access
// (R14) one precharge state, two when precharge-count bit is set
// (R15) precharge-count bit also gives refresh two precharge states
// (R16) software picks precharge count to suit dram and clock
// (R17) row-wait bit inserts one row-wait state before first column
// (R18) three-state bit 1 inserts 0 to 3 column waits per area
// (R19) refresh ignores row-wait, three-state and wait-count settings
// (R20) external wait-request pin ignored in dram cycles
// (R21) three-bit area field designates dram areas and row strobe pins
// (R22) 8-bit dram space drives only the upper column strobe
// (R23) column waits hold address and strobes at first-column values
`timescale 1ns/1ns
`include "dram_seq_consts.vh"
module dram_access_sequencer #(
  parameter AW = 24
) (
  input  wire          clock,
  input  wire          rst,
  input  wire          req,
  input  wire          req_write,
  input  wire          req_refresh,
  input  wire [1:0]    req_area,
  input  wire [AW-1:0] req_addr,
  input  wire          next_is_ext,
  input  wire          wait_req_n,
  input  wire [1:0]    colwidth_sel,
  input  wire          mode_1mb,
  input  wire [2:0]    dram_area_field,
  input  wire [3:0]    area_buswidth_ctrl,
  input  wire [3:0]    area_state_ctrl,
  input  wire [7:0]    wait_count,
  input  wire          colstrobe_pin_sel,
  input  wire          precharge_count_bit,
  input  wire          row_wait_bit,
  output reg           busy_q,
  output reg           done_q,
  output reg  [AW-1:0] addr_pins_q,
  output reg  [3:0]    cs_n_q,
  output reg           portb_pin4_q,
  output reg           portb_pin5_q,
  output reg           high_write_strobe_q,
  output reg           low_write_strobe_q,
  output reg           read_strobe_q,
  output reg           refresh_indicator_q,
  output reg  [1:0]    byte_lane_en_q
);
  // ------------------------------------------------------------
  // area decode
  // ------------------------------------------------------------
  // returns row strobe pin index (0..3 = cs2..cs5) for an area
  function [2:0] ras_pin;
    input [2:0] fld;
    input [1:0] area;
    begin
      ras_pin = 3'h4; // 4 means normal space
      case (fld) // (R21)
        3'h1: if (area == 2'h0) ras_pin = 3'h0;
        3'h2: if (area <= 2'h1) ras_pin = {1'b0, area};
        3'h3: if (area <= 2'h1) ras_pin = 3'h0;
        3'h4: if (area <= 2'h2) ras_pin = {1'b0, area};
        3'h5: ras_pin = {1'b0, area};
        3'h6: ras_pin = (area >= 2'h2) ? 3'h2 : 3'h0;
        3'h7: ras_pin = 3'h0;
        default: ras_pin = 3'h4;
      endcase
    end
  endfunction

  reg  [2:0]    state_q, state_d;
  reg  [1:0]    cnt_q, cnt_d;
  reg           wr_q, rf_q, b8_q;
  reg  [1:0]    area_q;
  reg  [2:0]    pin_q;
  reg  [AW-1:0] addr_q;
  wire [AW-1:0] mux_pins;
  wire [2:0]    req_pin = ras_pin(dram_area_field, req_area);
  // pins are registered from next state, so the phase follows state_d
  wire          row_ph = (state_d == `ST_PRE) || (state_d == `ST_ROW) ||
                         (state_d == `ST_ROWW);
  // the wait-request pin is not looked at anywhere here
  wire          unused_wait = wait_req_n; // (R20)
  wire [1:0]    area_wait = wait_count[area_q*2 +: 2];

  addr_mux #(.AW(AW)) u_mux (
    .addr         (addr_q),
    .colwidth_sel (colwidth_sel),
    .mode_1mb     (mode_1mb),
    .row_phase    (row_ph),
    .pins         (mux_pins)
  );

  // ------------------------------------------------------------
  // state sequence
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      `ST_IDLE: begin
        if (req && (req_refresh || req_pin != 3'h4)) begin
          state_d = `ST_PRE; // (R11)
          cnt_d   = precharge_count_bit ? 2'h1 : 2'h0; // (R14) (R15)
        end
      end
      `ST_PRE: begin
        if (cnt_q != 2'h0)
          cnt_d = cnt_q - 2'h1;
        else
          state_d = `ST_ROW;
      end
      `ST_ROW: begin
        // refresh skips row wait
        if (row_wait_bit && !rf_q) // (R17) (R19)
          state_d = `ST_ROWW;
        else
          state_d = `ST_COL1;
      end
      `ST_ROWW: state_d = `ST_COL1;
      `ST_COL1: begin
        if (!rf_q && area_state_ctrl[area_q] && area_wait != 2'h0) begin
          state_d = `ST_COLW; // (R12) (R18)
          cnt_d   = area_wait - 2'h1;
        end else
          state_d = `ST_COL2;
      end
      `ST_COLW: begin
        if (cnt_q != 2'h0)
          cnt_d = cnt_q - 2'h1;
        else
          state_d = `ST_COL2;
      end
      `ST_COL2: begin
        if (colstrobe_pin_sel && next_is_ext)
          state_d = `ST_GAP; // (R13)
        else
          state_d = `ST_IDLE;
      end
      `ST_GAP: state_d = `ST_IDLE;
      default: state_d = `ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // registers and pins
  // ------------------------------------------------------------
  wire in_col = (state_q == `ST_COL1) || (state_q == `ST_COLW) ||
                (state_q == `ST_COL2);
  wire n_col  = (state_d == `ST_COL1) || (state_d == `ST_COLW) ||
                (state_d == `ST_COL2);
  wire n_ras  = (state_d == `ST_ROW) || (state_d == `ST_ROWW) || n_col;
  // cas-before-ras: in refresh the column strobes assert in the same cycle as the row strobes
  wire n_cas  = rf_q ? n_ras : n_col;
  wire upper_col_strobe_n = !n_cas;
  wire lower_col_strobe_n = !(n_cas && !b8_q); // (R22)
  integer k;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q             <= `ST_IDLE;
      cnt_q               <= 2'h0;
      wr_q                <= 1'b0;
      rf_q                <= 1'b0;
      b8_q                <= 1'b0;
      area_q              <= 2'h0;
      pin_q               <= 3'h4;
      addr_q              <= {AW{1'b0}};
      busy_q              <= 1'b0;
      done_q              <= 1'b0;
      addr_pins_q         <= {AW{1'b0}};
      cs_n_q              <= 4'hF;
      portb_pin4_q        <= 1'b1;
      portb_pin5_q        <= 1'b1;
      high_write_strobe_q <= 1'b1;
      low_write_strobe_q  <= 1'b1;
      read_strobe_q       <= 1'b1;
      refresh_indicator_q <= 1'b1;
      byte_lane_en_q      <= 2'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (state_q == `ST_IDLE && state_d == `ST_PRE) begin
        wr_q   <= req_write && !req_refresh;
        rf_q   <= req_refresh;
        area_q <= req_area;
        b8_q   <= area_buswidth_ctrl[req_area]; // (R5)
        pin_q  <= req_refresh ? 3'h4 : req_pin;
        addr_q <= req_addr;
      end
      busy_q <= (state_d != `ST_IDLE);
      done_q <= (state_q == `ST_COL2);
      // address frozen through column waits
      if (state_d != `ST_COLW)
        addr_pins_q <= mux_pins; // (R2) (R4) (R23)
      for (k = 0; k < 4; k = k + 1) begin
        // refresh strobes every dram row strobe pin
        if (rf_q)
          cs_n_q[k] <= !n_ras;
        else
          cs_n_q[k] <= !(n_ras && pin_q == k); // (R8)
      end
      if (colstrobe_pin_sel) begin // (R7)
        portb_pin4_q        <= 1'b1;
        portb_pin5_q        <= 1'b1;
        high_write_strobe_q <= upper_col_strobe_n;
        low_write_strobe_q  <= lower_col_strobe_n;
      end else begin
        portb_pin4_q        <= upper_col_strobe_n;
        portb_pin5_q        <= lower_col_strobe_n;
        high_write_strobe_q <= 1'b1;
        low_write_strobe_q  <= 1'b1;
      end
      read_strobe_q <= !(wr_q && n_ras && state_d != `ST_GAP); // (R9)
      refresh_indicator_q <= !(rf_q && state_d != `ST_IDLE &&
                               state_d != `ST_GAP); // (R10)
      if (n_col && !rf_q)
        byte_lane_en_q <= b8_q ? 2'h2 : 2'h3; // (R6)
      else
        byte_lane_en_q <= 2'h0;
    end
  end
endmodule

// ### sim/dram_seq_props.sv
// concurrent checks on the sequencer outputs
`timescale 1ns/1ns
module dram_seq_props #(
  parameter AW = 24
) (
  input wire          clock,
  input wire          rst,
  input wire          busy_q,
  input wire          done_q,
  input wire [AW-1:0] addr_pins_q,
  input wire [3:0]    cs_n_q,
  input wire          portb_pin4_q,
  input wire          portb_pin5_q,
  input wire          high_write_strobe_q,
  input wire          low_write_strobe_q,
  input wire          read_strobe_q,
  input wire          refresh_indicator_q,
  input wire [1:0]    byte_lane_en_q,
  input wire          colstrobe_pin_sel
);
  wire upper_col_strobe_n = colstrobe_pin_sel ? high_write_strobe_q : portb_pin4_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  we_in_access_a: assert property (!read_strobe_q |-> busy_q)
    else $error("write enable outside access");
  refresh_indicator_idle_a: assert property (!busy_q |-> refresh_indicator_q)
    else $error("refresh indicator low while idle");
  lane_upper_a: assert property (byte_lane_en_q != 2'h1)
    else $error("lower lane without upper lane");
  lower_col_strobe_upper_col_strobe_a: assert property ((low_write_strobe_q || !high_write_strobe_q)
    && (portb_pin5_q || !portb_pin4_q)) else $error("lower strobe alone");
  strobe_pins_a: assert property (busy_q |-> (colstrobe_pin_sel ?
    portb_pin4_q && portb_pin5_q : high_write_strobe_q && low_write_strobe_q))
    else $error("column strobe on unselected pins");
  precharge_first_a: assert property ($rose(busy_q) |-> cs_n_q == 4'hF)
    else $error("row strobe without precharge");
  state_count_a: assert property ($rose(busy_q) |-> busy_q[*4] ##[1:9] done_q)
    else $error("access state count wrong");
  col_hold_a: assert property (refresh_indicator_q && !upper_col_strobe_n && !$past(upper_col_strobe_n)
    |-> $stable(addr_pins_q) && $stable(cs_n_q)) else $error("column wait moved");
endmodule
bind dram_access_sequencer dram_seq_props #(.AW(AW)) props_u (.clock, .rst,
  .busy_q, .done_q, .addr_pins_q, .cs_n_q, .portb_pin4_q, .portb_pin5_q,
  .high_write_strobe_q, .low_write_strobe_q, .read_strobe_q,
  .refresh_indicator_q, .byte_lane_en_q, .colstrobe_pin_sel);

// ### sim/dram_chip_model.sv
// behavioural dram that latches the row and column address it is given
`timescale 1ns/1ns
module dram_chip_model (
  input  wire        clock,
  input  wire [3:0]  ras_n,
  input  wire        cas_n,
  input  wire [23:0] pins,
  output reg  [23:0] row_q,
  output reg  [23:0] col_q
);
  reg ras_d_q;
  reg cas_d_q;
  // strobes are registered at the source, so last-cycle values avoid races
  always @(posedge clock) begin
    ras_d_q <= &ras_n;
    cas_d_q <= cas_n;
    if (ras_d_q && !(&ras_n)) row_q <= pins;
    if (cas_d_q && !cas_n) col_q <= pins;
  end
endmodule

// ### sim/dram_access_sequencer_bench.sv
// random and corner tests for the dram access sequencer
`timescale 1ns/1ns
module dram_access_sequencer_bench;
  reg         clock, rst, req, req_write, req_refresh, next_is_ext, l8;
  reg         wait_req_n, mode_1mb, colstrobe_pin_sel;
  reg         precharge_count_bit, row_wait_bit;
  reg  [1:0]  req_area, colwidth_sel;
  reg  [2:0]  dram_area_field;
  reg  [3:0]  area_buswidth_ctrl, area_state_ctrl;
  reg  [7:0]  wait_count;
  reg  [23:0] req_addr, m;
  reg  [31:0] rs;
  wire        busy_q, done_q, portb_pin4_q, portb_pin5_q, read_strobe_q;
  wire        high_write_strobe_q, low_write_strobe_q, refresh_indicator_q;
  wire [3:0]  cs_n_q;
  wire [1:0]  byte_lane_en_q;
  wire [23:0] addr_pins_q, row_q, col_q;
  integer     miscompares, check_count, n, w, e, k, gap;
  wire upper_col_strobe_n = colstrobe_pin_sel ? high_write_strobe_q : portb_pin4_q;
  wire lower_col_strobe_n = colstrobe_pin_sel ? low_write_strobe_q : portb_pin5_q;
  dram_access_sequencer #(.AW(24)) dut_u (.clock, .rst, .req, .req_write,
    .req_refresh, .req_area, .req_addr, .next_is_ext, .wait_req_n,
    .colwidth_sel, .mode_1mb, .dram_area_field, .area_buswidth_ctrl,
    .area_state_ctrl, .wait_count, .colstrobe_pin_sel, .precharge_count_bit,
    .row_wait_bit, .busy_q, .done_q, .addr_pins_q, .cs_n_q, .portb_pin4_q,
    .portb_pin5_q, .high_write_strobe_q, .low_write_strobe_q,
    .read_strobe_q, .refresh_indicator_q, .byte_lane_en_q);
  dram_chip_model mem_u (.clock, .ras_n(cs_n_q), .cas_n(upper_col_strobe_n),
    .pins(addr_pins_q), .row_q, .col_q);
  always #10 clock = ~clock;
  // ------------------------------------------------
  // helpers
  // ------------------------------------------------
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      xs = y ^ (y << 5);
    end
  endfunction
  function [23:0] row_exp(input [23:0] a, input [1:0] cw);
    integer i;
    begin
      row_exp = a;
      for (i = 0; i <= 12 - cw; i = i + 1) row_exp[i] = a[i + 8 + cw];
    end
  endfunction
  task chk(input ok);
    begin
      check_count = check_count + 1;
      if (ok !== 1'b1) begin
        miscompares = miscompares + 1;
        $display("Error %0t: output mismatch", $time);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task run;
    begin
      @(posedge clock);
      rs = xs(rs);
      req_addr <= rs[23:0];
      rs = xs(rs);
      {req_write, req_area, mode_1mb, colstrobe_pin_sel, precharge_count_bit,
        row_wait_bit, area_buswidth_ctrl, area_state_ctrl, wait_count,
        wait_req_n, next_is_ext} <= rs[24:0];
      colwidth_sel <= (rs[26:25] == 2'h3) ? 2'h0 : rs[26:25];
      req_refresh <= (rs[29:27] == 3'h0);
      req <= 1'b1;
      // let the last sequencer update settle before looking at busy_q
      #1 w = 0;
      while (busy_q !== 1'b1 && w < 20) begin
        @(posedge clock);
        #1 w = w + 1;
      end
      chk(w == 1);
      l8 = area_buswidth_ctrl[req_area];
      n = 1;
      while (done_q !== 1'b1 && n < 20) begin
        @(posedge clock);
        req <= 1'b0;
        #1 if (busy_q === 1'b1 && done_q !== 1'b1) n = n + 1;
        chk(req_refresh || (cs_n_q | (4'h1 << req_area)) === 4'hF);
        if (!req_refresh && !upper_col_strobe_n) chk(lower_col_strobe_n === l8);
        if (!req_refresh && !upper_col_strobe_n)
          chk(byte_lane_en_q === (l8 ? 2'h2 : 2'h3));
        if (!req_write) chk(read_strobe_q === 1'b1);
        if (cs_n_q != 4'hF) chk(refresh_indicator_q === !req_refresh);
      end
      e = (precharge_count_bit ? 2 : 1) + 3 + (req_refresh ? 0 : row_wait_bit
        + (area_state_ctrl[req_area] ? wait_count[2*req_area +: 2] : 0));
      chk(n == e);
      m = mode_1mb ? ~(24'h1 << (12 - colwidth_sel)) : 24'hFFFFFF;
      if (!req_refresh) chk((row_q & m) === (row_exp(req_addr, colwidth_sel) & m));
      if (!req_refresh) chk(col_q === req_addr);
      // the gap state keeps busy_q up for the cycle in which done_q pulses
      gap = colstrobe_pin_sel & next_is_ext;
      chk(busy_q === gap[0]);
    end
  endtask
  initial begin
    {clock, req, req_write, req_refresh, next_is_ext, wait_req_n} = 6'h00;
    {mode_1mb, colstrobe_pin_sel, precharge_count_bit, row_wait_bit} = 4'h0;
    {req_area, colwidth_sel, area_buswidth_ctrl, area_state_ctrl} = 12'h000;
    {wait_count, req_addr} = 32'h00000000;
    dram_area_field = 3'h5;
    rst = 1'b1;
    rs = 32'h0000CFCE;
    {miscompares, check_count, gap} = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    // normal space only: the request must be ignored
    @(posedge clock);
    dram_area_field <= 3'h0;
    req <= 1'b1;
    repeat (4) @(posedge clock);
    #1 chk(busy_q === 1'b0);
    @(posedge clock);
    dram_area_field <= 3'h5;
    req <= 1'b0;
    for (k = 0; k < 200; k = k + 1) run;
    give_verdict;
  end
  initial begin
    #200000;
    miscompares = miscompares + 1;
    give_verdict;
  end
endmodule
